/* File: design/simd_pkg.sv */
// Shared constants, operation codes and carrier types for the packed FP datapath.
package simd_pkg;

    // ==================================================================
    // Number formats
    localparam int SP_EW = 8;
    localparam int SP_MW = 23;
    localparam int DP_EW = 11;
    localparam int DP_MW = 52;
    // Double bias plus mantissa width: right shift that leaves the integer part.
    localparam int DP_INT_SHIFT = 1075;

    // ==================================================================
    // Rounding control encodings, shared by the vector and x87 control words
    localparam logic [1:0] RC_NEAR = 2'h0;
    localparam logic [1:0] RC_DOWN = 2'h1;
    localparam logic [1:0] RC_UP = 2'h2;
    localparam logic [1:0] RC_ZERO = 2'h3;

    // Integer store answer for NaN, infinity and out-of-range values.
    localparam logic [31:0] INT_INDEF = 32'h8000_0000;

    // ==================================================================
    // Unaligned load: memory is fetched in aligned 16-byte chunks
    localparam int CHUNK_OFS_W = 4;
    localparam logic [31:0] CHUNK_BYTES = 32'h0000_0010;

    // ==================================================================
    // Operations and states
    typedef enum logic [3:0] {
        OP_ALT_ADDSUB_SINGLE = 4'h0,
        OP_ALT_ADDSUB_DOUBLE = 4'h1,
        OP_HORIZ_ADD_SINGLE = 4'h2,
        OP_HORIZ_SUB_SINGLE = 4'h3,
        OP_HORIZ_ADD_DOUBLE = 4'h4,
        OP_HORIZ_SUB_DOUBLE = 4'h5,
        OP_DUP_ODD_ELEMENTS = 4'h6,
        OP_DUP_EVEN_ELEMENTS = 4'h7,
        OP_DUP_QUADWORD = 4'h8,
        OP_UNALIGNED_128_LOAD = 4'h9,
        OP_TRUNCATING_INT_STORE = 4'ha,
        OP_ROUNDING_INT_STORE = 4'hb
    } op_e;

    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_EXEC = 2'h1,
        S_LD_LO = 2'h3,
        S_LD_HI = 2'h2
    } state_e;

    typedef struct packed {
        op_e op;
        logic [127:0] a;
        logic [127:0] b;
        logic [31:0] addr;
        logic [1:0] vec_rc;
        logic [1:0] x87_rc;
    } req_s;

    localparam req_s REQ_RST = '0;

endpackage

/* File: design/fp_addsub.sv */
// One binary floating-point lane adder/subtractor with selectable rounding.
module fp_addsub #(
    parameter int EW = 8,
    parameter int MW = 23
) (
    input wire logic [EW+MW:0] a_i,   // first operand
    input wire logic [EW+MW:0] b_i,   // second operand
    input wire logic sub_i,           // high: a minus b
    input wire logic [1:0] rmode_i,   // rounding control
    output logic [EW+MW:0] y_o        // rounded result
);
    // Hidden bit, mantissa, then guard, round and sticky.
    localparam int FW = MW + 4;
    localparam logic [EW-1:0] EMAX = '1;

    logic swap, sgn, eff_sub, lost, inc;
    logic [EW+MW-1:0] big, sml;
    logic [EW-1:0] ea, eb;
    logic [EW+1:0] e;
    logic [FW-1:0] ma, mb, sh;
    logic [FW:0] s;
    logic [MW+1:0] m;
    int d;

    // ==================================================================
    // Align, add, normalise, round
    always_comb begin
        swap = b_i[EW+MW-1:0] > a_i[EW+MW-1:0];
        sgn = swap ? (b_i[EW+MW] ^ sub_i) : a_i[EW+MW];
        eff_sub = a_i[EW+MW] ^ b_i[EW+MW] ^ sub_i;
        big = swap ? b_i[EW+MW-1:0] : a_i[EW+MW-1:0];
        sml = swap ? a_i[EW+MW-1:0] : b_i[EW+MW-1:0];
        ea = (big[EW+MW-1:MW] == '0) ? EW'(1) : big[EW+MW-1:MW];
        eb = (sml[EW+MW-1:MW] == '0) ? EW'(1) : sml[EW+MW-1:MW];
        ma = {|big[EW+MW-1:MW], big[MW-1:0], 3'h0};
        mb = {|sml[EW+MW-1:MW], sml[MW-1:0], 3'h0};
        d = int'(ea) - int'(eb);
        sh = mb;
        lost = 1'b0;
        for (int i = 0; i < FW; i++) begin
            if (i < d) begin
                lost = lost | sh[0];
                sh = sh >> 1;
            end
        end
        // Shifted-out bits fold into sticky so subtraction still rounds right.
        sh[0] = sh[0] | lost;
        s = eff_sub ? ({1'b0, ma} - {1'b0, sh}) : ({1'b0, ma} + {1'b0, sh});
        e = {2'h0, ea};
        if (s[FW]) begin
            s = {1'b0, s[FW:2], s[1] | s[0]};
            e = e + 1'b1;
        end
        for (int i = 0; i < FW; i++) begin
            if (!s[FW-1] && e > 1) begin
                s = {s[FW-1:0], 1'b0};
                e = e - 1'b1;
            end
        end
        if (!s[FW-1]) begin
            e = '0;
        end
        case (rmode_i)
            simd_pkg::RC_NEAR: inc = s[2] & (s[1] | s[0] | s[3]);
            simd_pkg::RC_DOWN: inc = sgn & (|s[2:0]);
            simd_pkg::RC_UP: inc = !sgn & (|s[2:0]);
            default: inc = 1'b0;
        endcase
        m = {1'b0, s[FW-1:3]} + (MW+2)'(inc);
        if (m[MW+1]) begin
            m = m >> 1;
            e = e + 1'b1;
        end else if (e == '0 && m[MW]) begin
            e = (EW+2)'(1);
        end
        if (e >= {2'h0, EMAX}) begin
            y_o = {sgn, EMAX, {MW{1'b0}}};
        end else begin
            y_o = {sgn, e[EW-1:0], m[MW-1:0]};
        end
        if (s == '0) begin
            y_o = {eff_sub ? (rmode_i == simd_pkg::RC_DOWN) : sgn, {(EW+MW){1'b0}}};
        end
        // A NaN always sorts as the larger magnitude, so only big is checked.
        if (big[EW+MW-1:MW] == EMAX) begin
            if (big[MW-1:0] != '0) begin
                y_o = {sgn, EMAX, 1'b1, big[MW-2:0]};
            end else if (sml[EW+MW-1:MW] == EMAX && eff_sub) begin
                y_o = {1'b1, EMAX, 1'b1, {(MW-1){1'b0}}};
            end else begin
                y_o = {sgn, big};
            end
        end
    end

endmodule

/* File: design/fp_to_int.sv */
// Double-precision to 32-bit signed integer conversion with selectable rounding.
module fp_to_int (
    input wire logic [63:0] x_i,      // double-precision source
    input wire logic [1:0] rmode_i,   // rounding control
    output logic [31:0] q_o           // integer result
);
    logic sgn, g, st, inc;
    logic [10:0] e;
    logic [52:0] v;
    logic [53:0] mag, neg, lim;
    int k;

    always_comb begin
        sgn = x_i[63];
        e = x_i[62:52];
        v = {|e, x_i[51:0]};
        g = 1'b0;
        st = 1'b0;
        k = simd_pkg::DP_INT_SHIFT - int'(e);
        for (int i = 0; i < 64; i++) begin
            if (i < k) begin
                st = st | g;
                g = v[0];
                v = v >> 1;
            end
        end
        case (rmode_i)
            simd_pkg::RC_NEAR: inc = g & (st | v[0]);
            simd_pkg::RC_DOWN: inc = sgn & (g | st);
            simd_pkg::RC_UP: inc = !sgn & (g | st);
            default: inc = 1'b0;
        endcase
        mag = {1'b0, v} + 54'(inc);
        neg = ~mag + 54'h1;
        // Negative side reaches one further than the positive side.
        lim = 54'h7fff_ffff + 54'(sgn);
        if (k <= 0 || mag > lim) begin
            q_o = simd_pkg::INT_INDEF;
        end else begin
            q_o = sgn ? neg[31:0] : mag[31:0];
        end
    end

endmodule

/* File: design/simd_fp_horizontal_addsub_dup.sv */
// Packed FP add/sub, horizontal, duplicate, unaligned load and integer store datapath.
// Notes on behaviour
// RULE1: Truncating store always rounds toward zero.
// RULE2: Single alternating: lanes 0,2 subtract, 1,3 add.
// RULE3: Double alternating: low lane subtracts, high adds.
// RULE4: Single horizontal add pairs adjacent elements.
// RULE5: Single horizontal subtract: even minus odd element.
// RULE6: Double horizontal add: sum per operand.
// RULE7: Double horizontal subtract: element 0 minus 1.
// RULE8: Odd duplicate copies elements 1 and 3.
// RULE9: Even duplicate copies elements 0 and 2.
// RULE10: Quadword duplicate copies low 64 bits twice.
// RULE11: Unaligned load may span a cache line, reading two aligned chunks.
// RULE12: Lane arithmetic uses vector control rounding.
module simd_fp_horizontal_addsub_dup (
    input wire logic REF_CLK_I,                   // core clock
    input wire logic RST_I,                       // synchronous reset, active high
    input wire logic REQ_VALID_I,                 // operation request
    input wire simd_pkg::op_e REQ_OP_I,           // operation code
    input wire logic [127:0] SRC_A_I,             // first operand / source
    input wire logic [127:0] SRC_B_I,             // second operand
    input wire logic [31:0] REQ_ADDR_I,           // byte address for the load
    input wire logic [1:0] VEC_RC_I,              // vector control rounding field
    input wire logic [1:0] FP_CONTROL_WORD_RC_I,  // x87 control word rounding field
    input wire logic [127:0] MEM_RD_DATA_I,       // aligned chunk read data
    input wire logic MEM_RD_VALID_I,              // read data valid
    output logic READY_O,                         // block can take a request
    output logic RES_VALID_O,                     // result pulse
    output logic [127:0] RES_DATA_O,              // result data
    output logic MEM_RD_O,                        // aligned chunk read pulse
    output logic [31:0] MEM_RD_ADDR_O             // aligned chunk address
);
    // ==================================================================
    // State
    simd_pkg::state_e state_r, state_nxt;
    simd_pkg::req_s req_r, req_nxt;
    logic ready_r, ready_nxt;
    logic res_valid_r, res_valid_nxt;
    logic [127:0] res_r, res_nxt;
    logic mem_rd_r, mem_rd_nxt;
    logic [31:0] mem_addr_r, mem_addr_nxt;
    logic [127:0] lo_r, lo_nxt;

    logic accept;
    logic [3:0][31:0] sx, sy, sr;
    logic [3:0] ssub;
    logic [1:0][63:0] dx, dy, dr;
    logic [1:0] dsub;
    logic [1:0] cvt_rc;
    logic [31:0] cvt_q;
    logic [127:0] arith;
    logic [255:0] merged;
    localparam int CHUNK_W = simd_pkg::CHUNK_OFS_W;
    logic [CHUNK_W-1:0] ofs;


    assign accept = ready_r && REQ_VALID_I;
    assign ofs = req_r.addr[CHUNK_W-1:0];

    // ==================================================================
    // Lane operand steering
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sx[i] = req_r.a[32*i +: 32];
            sy[i] = req_r.b[32*i +: 32];
        end
        ssub = 4'h5;                                             // [RULE2]
        if (req_r.op == simd_pkg::OP_HORIZ_ADD_SINGLE ||
            req_r.op == simd_pkg::OP_HORIZ_SUB_SINGLE) begin
            sx[0] = req_r.a[31:0];                               // [RULE4] [RULE5]
            sy[0] = req_r.a[63:32];
            sx[1] = req_r.a[95:64];
            sy[1] = req_r.a[127:96];
            sx[2] = req_r.b[31:0];
            sy[2] = req_r.b[63:32];
            sx[3] = req_r.b[95:64];
            sy[3] = req_r.b[127:96];
            ssub = {4{req_r.op == simd_pkg::OP_HORIZ_SUB_SINGLE}};
        end
        dx[0] = req_r.a[63:0];
        dy[0] = req_r.b[63:0];
        dx[1] = req_r.a[127:64];
        dy[1] = req_r.b[127:64];
        dsub = 2'h1;                                             // [RULE3]
        if (req_r.op == simd_pkg::OP_HORIZ_ADD_DOUBLE ||
            req_r.op == simd_pkg::OP_HORIZ_SUB_DOUBLE) begin
            dx[0] = req_r.a[63:0];                               // [RULE6] [RULE7]
            dy[0] = req_r.a[127:64];
            dx[1] = req_r.b[63:0];
            dy[1] = req_r.b[127:64];
            dsub = {2{req_r.op == simd_pkg::OP_HORIZ_SUB_DOUBLE}};
        end
    end

    // ==================================================================
    // Arithmetic lanes
    generate
        for (genvar i = 0; i < 4; i++) begin : g_sp
            fp_addsub #(.EW(simd_pkg::SP_EW), .MW(simd_pkg::SP_MW)) u_sp (
                .a_i(sx[i]),
                .b_i(sy[i]),
                .sub_i(ssub[i]),
                .rmode_i(req_r.vec_rc),                          // [RULE12]
                .y_o(sr[i])
            );
        end
        for (genvar j = 0; j < 2; j++) begin : g_dp
            fp_addsub #(.EW(simd_pkg::DP_EW), .MW(simd_pkg::DP_MW)) u_dp (
                .a_i(dx[j]),
                .b_i(dy[j]),
                .sub_i(dsub[j]),
                .rmode_i(req_r.vec_rc),                          // [RULE12]
                .y_o(dr[j])
            );
        end
    endgenerate

    // The x87 control word is bypassed, not rewritten, for the truncating form.
    assign cvt_rc = (req_r.op == simd_pkg::OP_TRUNCATING_INT_STORE) ?
                    simd_pkg::RC_ZERO : req_r.x87_rc;            // [RULE1]

    fp_to_int u_cvt (
        .x_i(req_r.a[63:0]),
        .rmode_i(cvt_rc),
        .q_o(cvt_q)
    );

    // ==================================================================
    // Result selection
    always_comb begin
        case (req_r.op)
            simd_pkg::OP_ALT_ADDSUB_SINGLE,
            simd_pkg::OP_HORIZ_ADD_SINGLE,
            simd_pkg::OP_HORIZ_SUB_SINGLE: arith = sr;
            simd_pkg::OP_ALT_ADDSUB_DOUBLE,
            simd_pkg::OP_HORIZ_ADD_DOUBLE,
            simd_pkg::OP_HORIZ_SUB_DOUBLE: arith = dr;
            simd_pkg::OP_DUP_ODD_ELEMENTS: arith = {req_r.a[127:96], req_r.a[127:96],
                req_r.a[63:32], req_r.a[63:32]};                 // [RULE8]
            simd_pkg::OP_DUP_EVEN_ELEMENTS: arith = {req_r.a[95:64], req_r.a[95:64],
                req_r.a[31:0], req_r.a[31:0]};                   // [RULE9]
            simd_pkg::OP_DUP_QUADWORD: arith = {req_r.a[63:0], req_r.a[63:0]}; // [RULE10]
            simd_pkg::OP_TRUNCATING_INT_STORE,
            simd_pkg::OP_ROUNDING_INT_STORE: arith = {96'h0, cvt_q};
            default: arith = 128'h0;
        endcase
    end

    // Low chunk sits at the lower address, so the pair is shifted down by the offset.
    assign merged = {MEM_RD_DATA_I, lo_r} >> {ofs, 3'h0};

    // ==================================================================
    // Sequencing
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        res_valid_nxt = 1'b0;
        res_nxt = res_r;
        mem_rd_nxt = 1'b0;
        mem_addr_nxt = mem_addr_r;
        lo_nxt = lo_r;
        case (state_r)
            simd_pkg::S_IDLE: begin
                if (accept) begin
                    req_nxt = '{op: REQ_OP_I, a: SRC_A_I, b: SRC_B_I, addr: REQ_ADDR_I,
                        vec_rc: VEC_RC_I, x87_rc: FP_CONTROL_WORD_RC_I};
                    if (REQ_OP_I == simd_pkg::OP_UNALIGNED_128_LOAD) begin
                        // Only whole aligned chunks are fetched, never a line split.
                        mem_rd_nxt = 1'b1;
                        mem_addr_nxt = {REQ_ADDR_I[31:CHUNK_W], {CHUNK_W{1'b0}}}; // [RULE11]
                        state_nxt = simd_pkg::S_LD_LO;
                    end else begin
                        state_nxt = simd_pkg::S_EXEC;
                    end
                end
            end
            simd_pkg::S_EXEC: begin
                res_nxt = arith;
                res_valid_nxt = 1'b1;
                state_nxt = simd_pkg::S_IDLE;
            end
            simd_pkg::S_LD_LO: begin
                if (MEM_RD_VALID_I) begin
                    lo_nxt = MEM_RD_DATA_I;
                    if (ofs == '0) begin
                        res_nxt = MEM_RD_DATA_I;
                        res_valid_nxt = 1'b1;
                        state_nxt = simd_pkg::S_IDLE;
                    end else begin
                        mem_rd_nxt = 1'b1;
                        mem_addr_nxt = mem_addr_r + simd_pkg::CHUNK_BYTES; // [RULE11]
                        state_nxt = simd_pkg::S_LD_HI;
                    end
                end
            end
            default: begin
                if (MEM_RD_VALID_I) begin
                    res_nxt = merged[127:0];
                    res_valid_nxt = 1'b1;
                    state_nxt = simd_pkg::S_IDLE;
                end
            end
        endcase
        ready_nxt = (state_nxt == simd_pkg::S_IDLE);
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_r <= simd_pkg::S_IDLE;
            req_r <= simd_pkg::REQ_RST;
            ready_r <= 1'b0;
            res_valid_r <= 1'b0;
            res_r <= 128'h0;
            mem_rd_r <= 1'b0;
            mem_addr_r <= 32'h0;
            lo_r <= 128'h0;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            ready_r <= ready_nxt;
            res_valid_r <= res_valid_nxt;
            res_r <= res_nxt;
            mem_rd_r <= mem_rd_nxt;
            mem_addr_r <= mem_addr_nxt;
            lo_r <= lo_nxt;
        end
    end

    assign READY_O = ready_r;
    assign RES_VALID_O = res_valid_r;
    assign RES_DATA_O = res_r;
    assign MEM_RD_O = mem_rd_r;
    assign MEM_RD_ADDR_O = mem_addr_r;

    // ==================================================================
    // Checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_arith_take;
        accept && REQ_OP_I != simd_pkg::OP_UNALIGNED_128_LOAD;
    endsequence
    sequence s_load_take;
        accept && REQ_OP_I == simd_pkg::OP_UNALIGNED_128_LOAD;
    endsequence

    AST_TRUNC_ZERO: assert property (                                    // [RULE1]
        s_arith_take ##1 (req_r.op == simd_pkg::OP_TRUNCATING_INT_STORE)
        |-> cvt_rc == simd_pkg::RC_ZERO ##1 RES_VALID_O && RES_DATA_O[127:32] == 96'h0)
        else $error("truncating store did not round toward zero");
    AST_ALT_SINGLE: assert property (                                    // [RULE2]
        state_r == simd_pkg::S_EXEC && req_r.op == simd_pkg::OP_ALT_ADDSUB_SINGLE
        |-> ssub == 4'h5 && sx[1] == req_r.a[63:32] && sy[3] == req_r.b[127:96])
        else $error("single alternating lanes misrouted");
    AST_ALT_DOUBLE: assert property (                                    // [RULE3]
        state_r == simd_pkg::S_EXEC && req_r.op == simd_pkg::OP_ALT_ADDSUB_DOUBLE
        |-> dsub == 2'h1 && dy[1] == req_r.b[127:64])
        else $error("double alternating lanes misrouted");
    AST_HADD_SINGLE: assert property (                                   // [RULE4]
        state_r == simd_pkg::S_EXEC && req_r.op == simd_pkg::OP_HORIZ_ADD_SINGLE
        |-> ssub == 4'h0 && sy[1] == req_r.a[127:96] && sx[2] == req_r.b[31:0])
        else $error("single horizontal add pairing wrong");
    AST_HSUB_SINGLE: assert property (                                   // [RULE5]
        state_r == simd_pkg::S_EXEC && req_r.op == simd_pkg::OP_HORIZ_SUB_SINGLE
        |-> ssub == 4'hf && sx[3] == req_r.b[95:64] && sy[0] == req_r.a[63:32])
        else $error("single horizontal subtract pairing wrong");
    AST_HADD_DOUBLE: assert property (                                   // [RULE6]
        state_r == simd_pkg::S_EXEC && req_r.op == simd_pkg::OP_HORIZ_ADD_DOUBLE
        |-> dsub == 2'h0 && dy[0] == req_r.a[127:64] && dx[1] == req_r.b[63:0])
        else $error("double horizontal add pairing wrong");
    AST_HSUB_DOUBLE: assert property (                                   // [RULE7]
        state_r == simd_pkg::S_EXEC && req_r.op == simd_pkg::OP_HORIZ_SUB_DOUBLE
        |-> dsub == 2'h3 && dx[0] == req_r.a[63:0] && dy[1] == req_r.b[127:64])
        else $error("double horizontal subtract pairing wrong");
    AST_DUP_ODD: assert property (                                       // [RULE8]
        s_arith_take ##1 (req_r.op == simd_pkg::OP_DUP_ODD_ELEMENTS)
        |=> RES_VALID_O && RES_DATA_O[31:0] == req_r.a[63:32]
            && RES_DATA_O[95:64] == req_r.a[127:96])
        else $error("odd duplicate result wrong");
    AST_DUP_EVEN: assert property (                                      // [RULE9]
        s_arith_take ##1 (req_r.op == simd_pkg::OP_DUP_EVEN_ELEMENTS)
        |=> RES_VALID_O && RES_DATA_O[63:32] == req_r.a[31:0]
            && RES_DATA_O[127:96] == req_r.a[95:64])
        else $error("even duplicate result wrong");
    AST_DUP_QUAD: assert property (                                      // [RULE10]
        s_arith_take ##1 (req_r.op == simd_pkg::OP_DUP_QUADWORD)
        |=> RES_VALID_O && RES_DATA_O == {2{req_r.a[63:0]}})
        else $error("quadword duplicate result wrong");
    AST_LOAD_ALIGNED: assert property (                                  // [RULE11]
        MEM_RD_O |-> MEM_RD_ADDR_O[CHUNK_W-1:0] == '0)
        else $error("chunk read not aligned");
    AST_LOAD_START: assert property (                                    // [RULE11]
        s_load_take |=> MEM_RD_O && !READY_O
            && MEM_RD_ADDR_O[31:CHUNK_W] == $past(REQ_ADDR_I[31:CHUNK_W]))
        else $error("load did not fetch its first chunk");
    AST_VEC_ROUND: assert property (                                     // [RULE12]
        s_arith_take |=> req_r.vec_rc == $past(VEC_RC_I))
        else $error("vector rounding field not captured");
    AST_ARITH_LATENCY: assert property (
        s_arith_take |=> !READY_O ##1 RES_VALID_O && READY_O)
        else $error("result not two cycles after request");

endmodule

/* File: sim/mem_model.sv */
// Memory model that answers aligned 16-byte chunk reads after a set latency.
module mem_model (
    input wire logic clk_i,          // core clock
    input wire logic rd_i,           // chunk read pulse
    input wire logic [31:0] addr_i,  // aligned chunk address
    input wire logic [7:0] lat_i,    // answer latency in cycles, at least 1
    output logic [127:0] data_o,     // byte k holds address low byte plus k
    output logic valid_o             // data valid pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] a_r = '0;
    logic [7:0] cnt_r = '0;
    initial begin
        valid_o = 1'b0;
        data_o = '0;
    end
    // =================================================================
    // Answer
    always @(posedge clk_i) begin
        if (rd_i === 1'b1) begin
            a_r = addr_i;
            cnt_r = lat_i;
        end
        valid_o <= (cnt_r == 8'h01);
        // Outside a valid cycle every byte flips, so stale data cannot pass.
        for (int k = 0; k < 16; k++) begin
            data_o[8*k +: 8] <= (cnt_r == 8'h01) ? a_r[7:0] + 8'(k) : ~data_o[8*k +: 8];
        end
        if (cnt_r != 8'h00) cnt_r = cnt_r - 8'h01;
    end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the packed floating-point datapath.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    simd_pkg::req_s cur = simd_pkg::REQ_RST;
    logic [7:0] mem_lat = 8'h01;
    logic [127:0] mem_data, res_data;
    logic [31:0] mem_addr;
    logic mem_valid, ready, res_valid, mem_rd;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_reads = 0;

    simd_fp_horizontal_addsub_dup simd_fp_horizontal_addsub_dup_i (.REF_CLK_I(ref_clk),
        .RST_I(rst), .REQ_VALID_I(req_valid), .REQ_OP_I(cur.op), .SRC_A_I(cur.a),
        .SRC_B_I(cur.b), .REQ_ADDR_I(cur.addr), .VEC_RC_I(cur.vec_rc),
        .FP_CONTROL_WORD_RC_I(cur.x87_rc), .MEM_RD_DATA_I(mem_data),
        .MEM_RD_VALID_I(mem_valid), .READY_O(ready), .RES_VALID_O(res_valid),
        .RES_DATA_O(res_data), .MEM_RD_O(mem_rd), .MEM_RD_ADDR_O(mem_addr));
    mem_model mem_model_i (.clk_i(ref_clk), .rd_i(mem_rd), .addr_i(mem_addr),
        .lat_i(mem_lat), .data_o(mem_data), .valid_o(mem_valid));

    initial forever #2.5 ref_clk = ~ref_clk;

    // =================================================================
    // Checks and run control
    task automatic chk_data(input string n, input logic [127:0] e, input logic [127:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_num(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(negedge ref_clk) begin
        cycles <= cycles + 1;
        if (mem_rd === 1'b1) begin
            n_reads <= n_reads + 1;
            chk_num("chunk align", 32'h0, {28'h0, mem_addr[3:0]});
        end
        if (cycles == 4000) begin
            n_fail++;
            give_verdict;
        end
    end
    // Holds the request until an edge sees READY_O high, then waits for the result.
    task automatic run(output logic [127:0] res, output logic [31:0] w);
        @(negedge ref_clk);
        req_valid = 1'b1;
        while (ready !== 1'b1) @(negedge ref_clk);
        @(negedge ref_clk);
        req_valid = 1'b0;
        w = 32'h1;
        while (res_valid !== 1'b1 && w < 32'd200) begin
            @(negedge ref_clk);
            w++;
        end
        res = res_data;
    endtask
    task automatic expect_op(input string n, input simd_pkg::op_e op, input logic [127:0] e);
        logic [127:0] got;
        logic [31:0] w;
        cur.op = op;
        run(got, w);
        chk_data(n, e, got);
        chk_num("latency", 32'h2, w);
    endtask

    // =================================================================
    // Scenarios
    task automatic t_single;
        cur.a = 128'h41000000_40400000_40000000_3f800000;
        cur.b = 128'h3f800000_40800000_3f000000_3f800000;
        expect_op("alt s", simd_pkg::OP_ALT_ADDSUB_SINGLE,
            128'h41100000_bf800000_40200000_00000000);
        expect_op("hadd s", simd_pkg::OP_HORIZ_ADD_SINGLE,
            128'h40a00000_3fc00000_41300000_40400000);
        expect_op("hsub s", simd_pkg::OP_HORIZ_SUB_SINGLE,
            128'h40400000_3f000000_c0a00000_bf800000);
        $display("single test done");
    endtask
    task automatic t_double;
        cur.a = 128'h40000000_00000000_3ff00000_00000000;
        cur.b = 128'h3ff00000_00000000_40100000_00000000;
        expect_op("alt d", simd_pkg::OP_ALT_ADDSUB_DOUBLE,
            128'h40080000_00000000_c0080000_00000000);
        expect_op("hadd d", simd_pkg::OP_HORIZ_ADD_DOUBLE,
            128'h40140000_00000000_40080000_00000000);
        expect_op("hsub d", simd_pkg::OP_HORIZ_SUB_DOUBLE,
            128'h40080000_00000000_bff00000_00000000);
        $display("double test done");
    endtask
    task automatic t_dup;
        cur.a = 128'hdddddddd_cccccccc_bbbbbbbb_aaaaaaaa;
        expect_op("dup odd", simd_pkg::OP_DUP_ODD_ELEMENTS,
            {{2{32'hdddddddd}}, {2{32'hbbbbbbbb}}});
        expect_op("dup even", simd_pkg::OP_DUP_EVEN_ELEMENTS,
            {{2{32'hcccccccc}}, {2{32'haaaaaaaa}}});
        expect_op("dup quad", simd_pkg::OP_DUP_QUADWORD, {2{64'hbbbbbbbb_aaaaaaaa}});
        $display("dup test done");
    endtask
    // A half-ulp addend in the low lane separates round-up from the other three modes.
    task automatic t_round;
        cur.a = 128'h33800000_3f800000;
        cur.b = '0;
        for (int m = 0; m < 4; m++) begin
            cur.vec_rc = 2'(m);
            cur.x87_rc = ~cur.vec_rc;
            expect_op("round", simd_pkg::OP_HORIZ_ADD_SINGLE,
                128'h3f800000 + 128'(m == 2));
        end
        $display("round test done");
    endtask
    task automatic t_store;
        cur.a = 128'h40040000_00000000;
        cur.vec_rc = simd_pkg::RC_UP;
        for (int m = 0; m < 4; m++) begin
            cur.x87_rc = 2'(m);
            expect_op("trunc", simd_pkg::OP_TRUNCATING_INT_STORE, 128'h2);
        end
        cur.a = 128'hc0040000_00000000;
        cur.x87_rc = simd_pkg::RC_DOWN;
        expect_op("trunc neg", simd_pkg::OP_TRUNCATING_INT_STORE, 128'hfffffffe);
        expect_op("round neg", simd_pkg::OP_ROUNDING_INT_STORE, 128'hfffffffd);
        $display("store test done");
    endtask
    task automatic t_load(input logic [31:0] addr, input logic [7:0] lat);
        logic [127:0] e, got;
        logic [31:0] w;
        int r0;
        for (int k = 0; k < 16; k++) e[8*k +: 8] = addr[7:0] + 8'(k);
        mem_lat = lat;
        cur.addr = addr;
        cur.op = simd_pkg::OP_UNALIGNED_128_LOAD;
        r0 = n_reads;
        run(got, w);
        chk_data("load data", e, got);
        chk_num("chunk reads", (addr[3:0] == 4'h0) ? 32'h1 : 32'h2, 32'(n_reads - r0));
        $display("load test done at %h", addr);
    endtask

    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        t_single;
        t_double;
        t_dup;
        t_round;
        t_store;
        t_load(32'h00001230, 8'h01);
        t_load(32'h000012f7, 8'h04);
        t_load(32'h0000134f, 8'h01);
        give_verdict;
    end
endmodule
